// [core/dasr_pkg.sv]
// package: constants and carrier types of the dual converter serial readout
package dasr_pkg;
	// resolution selection
	typedef enum logic [1:0] {
		DASR_RES_16 = 2'b00,
		DASR_RES_14 = 2'b01,
		DASR_RES_12 = 2'b10
	} dasr_res_e;

	localparam int unsigned DASR_WORD_W      = 16;
	localparam int unsigned DASR_EDGE_W      = 6;
	localparam logic [5:0]  DASR_CONV_EDGES  = 6'h0e;
	localparam logic [5:0]  DASR_MSB_EDGE    = 6'h0f;
	localparam logic [5:0]  DASR_EDGE_MAX    = 6'h3f;
	localparam logic [5:0]  DASR_EDGE_RST    = 6'h00;
	localparam logic [15:0] DASR_WORD_RST    = 16'h0000;
	localparam logic [15:0] DASR_NEGATIVE_FULL_SCALE_CODE_16     = 16'h8000;
	localparam logic [15:0] DASR_NEGATIVE_FULL_SCALE_CODE_14     = 16'h2000;
	localparam logic [15:0] DASR_NEGATIVE_FULL_SCALE_CODE_12     = 16'h0800;
	localparam logic [15:0] DASR_POSITIVE_FULL_SCALE_CODE_16     = 16'h7fff;
	localparam logic [15:0] DASR_POSITIVE_FULL_SCALE_CODE_14     = 16'h1fff;
	localparam logic [15:0] DASR_POSITIVE_FULL_SCALE_CODE_12     = 16'h07ff;
	localparam logic [15:0] DASR_MASK_16     = 16'hffff;
	localparam logic [15:0] DASR_MASK_14     = 16'h3fff;
	localparam logic [15:0] DASR_MASK_12     = 16'h0fff;
	localparam logic [4:0]  DASR_BITS_16     = 5'h10;
	localparam logic [4:0]  DASR_BITS_14     = 5'h0e;
	localparam logic [4:0]  DASR_BITS_12     = 5'h0c;

	// serial pins seen by the device
	typedef struct packed {
		logic frame_sel_b;
		logic sclk;
	} dasr_pins_s;

	// one data pin, two signals
	typedef struct packed {
		logic dout;
		logic oe;
	} dasr_dout_s;
endpackage : dasr_pkg

// [core/dasr_sync.sv]
// three-flop input synchroniser with agreement filter
`timescale 1ns/1ns
`default_nettype none
module dasr_sync (
	input  wire logic clk_sys_i,   // system clock
	input  wire logic rst_b_i,     // sync reset, active low
	input  wire logic async_i,     // raw pin
	input  wire logic rst_val_i,   // level assumed at reset
	output var  logic level_o      // filtered level
);
	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic lvl;
	} dasr_sync_s;

	dasr_sync_s st;
	dasr_sync_s next_st;

	always_comb begin
		next_st    = st;
		next_st.s1 = async_i;
		next_st.s2 = st.s1;
		next_st.s3 = st.s2;
		if (st.s2 == st.s3) begin
			next_st.lvl = st.s3;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rst_b_i) begin
			st <= '{s1: rst_val_i, s2: rst_val_i, s3: rst_val_i, lvl: rst_val_i};
		end else begin
			st <= next_st;
		end
	end

	assign level_o = st.lvl;
endmodule // dasr_sync
`default_nettype wire

// [core/dasr_core.sv]
// dual converter frame control and serial result shifter
`timescale 1ns/1ns
`default_nettype none
module dasr_core
	import dasr_pkg::*;
(
	input  wire logic                       clk_sys_i,      // 25 MHz system clock
	input  wire logic                       rst_b_i,        // sync reset, active low
	input  wire dasr_pkg::dasr_pins_s       pins_i,         // chip select and serial clock
	input  wire dasr_pkg::dasr_res_e        res_i,          // resolution variant
	input  wire logic [15:0]                sample_a_i,     // channel A converter code
	input  wire logic [15:0]                sample_b_i,     // channel B converter code
	output var  dasr_pkg::dasr_dout_s       result_line_first_o,  // channel A data pin
	output var  dasr_pkg::dasr_dout_s       result_line_second_o, // channel B data pin
	output var  logic                       track_o,        // sample-and-hold tracking
	output var  logic                       frame_o,        // frame open
	output var  logic                       conv_done_o     // result held this frame
);
	import dasr_pkg::*;

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_CONV = 3'b010,
		ST_SHFT = 3'b100
	} dasr_state_e;

	typedef struct packed {
		dasr_state_e       fsm;
		logic              cs_d;
		logic              ck_d;
		logic [5:0]        edges;
		logic [15:0]       sh_a;
		logic [15:0]       sh_b;
		dasr_dout_s        line_a;
		dasr_dout_s        line_b;
		logic              track;
		logic              frame;
		logic              done;
	} dasr_core_s;

	dasr_core_s st;
	dasr_core_s next_st;

	logic cs_lvl;
	logic ck_lvl;

	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	dasr_sync u_sync_cs (
		.clk_sys_i (clk_sys_i),
		.rst_b_i   (rst_b_i),
		.async_i   (pins_i.frame_sel_b),
		.rst_val_i (1'b1),
		.level_o   (cs_lvl)
	);

	dasr_sync u_sync_ck (
		.clk_sys_i (clk_sys_i),
		.rst_b_i   (rst_b_i),
		.async_i   (pins_i.sclk),
		.rst_val_i (1'b1),
		.level_o   (ck_lvl)
	);

	// ------------------------------------------------------------
	// result alignment
	// ------------------------------------------------------------
	// left-justify a code of the chosen width; codes are already
	// two's complement, so the sign bit lands in the MSB slot
	function automatic logic [15:0] align(input logic [15:0] code, input dasr_res_e res);
		logic [15:0] v;
		v = DASR_WORD_RST;
		case (res)
			DASR_RES_16: v = code & DASR_MASK_16;
			DASR_RES_14: v = (code & DASR_MASK_14) << 2;
			DASR_RES_12: v = (code & DASR_MASK_12) << 4;
			default:     v = code & DASR_MASK_16;
		endcase
		return v;
	endfunction

	// ------------------------------------------------------------
	// aligned codes of both channels
	// ------------------------------------------------------------
	logic [15:0] al_a;
	logic [15:0] al_b;

	always_comb begin
		al_a = align(sample_a_i, res_i);
		al_b = align(sample_b_i, res_i);
	end

	// ------------------------------------------------------------
	// frame control
	// ------------------------------------------------------------
	logic cs_fall;
	logic cs_rise;
	logic ck_fall;

	always_comb begin
		cs_fall = st.cs_d & ~cs_lvl;
		cs_rise = ~st.cs_d & cs_lvl;
		ck_fall = st.ck_d & ~ck_lvl;
	end

	always_comb begin
		next_st      = st;
		next_st.cs_d = cs_lvl;
		next_st.ck_d = ck_lvl;
		case (st.fsm)
			ST_IDLE: begin
				if (cs_fall) begin
					next_st.fsm        = ST_CONV;
					next_st.edges      = DASR_EDGE_RST;
					next_st.track      = 1'b0;
					next_st.done       = 1'b0;
					next_st.frame      = 1'b1;
					next_st.line_a     = '{dout: 1'b0, oe: 1'b1};
					next_st.line_b     = '{dout: 1'b0, oe: 1'b1};
				end
			end
			ST_CONV: begin
				if (cs_rise) begin
					// short cycle: the host may close the frame at any time
					// conversion dropped, hold returns to tracking
					next_st.fsm    = ST_IDLE;
					next_st.frame  = 1'b0;
					next_st.track  = 1'b1;
					next_st.line_a = '{dout: 1'b0, oe: 1'b0};
					next_st.line_b = '{dout: 1'b0, oe: 1'b0};
				end else if (ck_fall) begin
					next_st.edges = st.edges + 6'h01;
					if (st.edges + 6'h01 == DASR_MSB_EDGE) begin
						// both channels captured together
						next_st.fsm         = ST_SHFT;
						next_st.track       = 1'b1;
						next_st.done        = 1'b1;
						next_st.sh_a        = al_a << 1;
						next_st.sh_b        = al_b << 1;
						next_st.line_a.dout = al_a[15];
						next_st.line_b.dout = al_b[15];
					end else begin
						next_st.line_a.dout = 1'b0;
						next_st.line_b.dout = 1'b0;
					end
				end
			end
			ST_SHFT: begin
				if (cs_rise) begin
					// bits already sent stay those of this sample
					next_st.fsm    = ST_IDLE;
					next_st.frame  = 1'b0;
					next_st.line_a = '{dout: 1'b0, oe: 1'b0};
					next_st.line_b = '{dout: 1'b0, oe: 1'b0};
				end else if (ck_fall) begin
					// count saturates so a long frame keeps shifting zeros
					if (st.edges != DASR_EDGE_MAX) begin
						next_st.edges = st.edges + 6'h01;
					end
					// zeros fill in behind the LSB
					next_st.line_a.dout = st.sh_a[15];
					next_st.line_b.dout = st.sh_b[15];
					next_st.sh_a        = st.sh_a << 1;
					next_st.sh_b        = st.sh_b << 1;
				end
			end
			default: begin
				next_st.fsm    = ST_IDLE;
				next_st.frame  = 1'b0;
				next_st.line_a = '{dout: 1'b0, oe: 1'b0};
				next_st.line_b = '{dout: 1'b0, oe: 1'b0};
			end
		endcase
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rst_b_i) begin
			st <= '{
				fsm:    ST_IDLE,
				cs_d:   1'b1,
				ck_d:   1'b1,
				edges:  DASR_EDGE_RST,
				sh_a:   DASR_WORD_RST,
				sh_b:   DASR_WORD_RST,
				line_a: '{dout: 1'b0, oe: 1'b0},
				line_b: '{dout: 1'b0, oe: 1'b0},
				track:  1'b1,
				frame:  1'b0,
				done:   1'b0
			};
		end else begin
			st <= next_st;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign result_line_first_o  = st.line_a;
	assign result_line_second_o = st.line_b;
	assign track_o              = st.track;
	assign frame_o              = st.frame;
	assign conv_done_o          = st.done;
endmodule // dasr_core
`default_nettype wire

// [dv/dasr_props.sv]
// checker: timing relations at the readout ports
`timescale 1ns/1ns
`default_nettype none
module dasr_props
	import dasr_pkg::*;
(
	input wire logic                 clk_sys_i,            // clock
	input wire logic                 rst_b_i,              // reset
	input wire dasr_pkg::dasr_pins_s pins_i,               // pins
	input wire dasr_pkg::dasr_dout_s result_line_first_o,  // line a
	input wire dasr_pkg::dasr_dout_s result_line_second_o, // line b
	input wire logic                 track_o,              // tracking
	input wire logic                 frame_o,              // frame
	input wire logic                 conv_done_o           // done
);
	dasr_dout_s la, lb;
	logic [2:0] age; // cycles since clock fell
	assign la = result_line_first_o;
	assign lb = result_line_second_o;
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!rst_b_i);
	sequence s_open; $fell(pins_i.frame_sel_b); endsequence
	sequence s_close; $rose(pins_i.frame_sel_b); endsequence
	always_ff @(posedge clk_sys_i)
		age <= (!rst_b_i || $fell(pins_i.sclk)) ? 3'h0 : (&age ? age : age + 3'h1);
	a_open_zero: assert property (s_open |-> ##[2:6] la.oe && lb.oe && !la.dout && !lb.dout)
		else $error("lines not low after open");
	a_close_release: assert property (s_close |-> ##[2:6] !la.oe && !lb.oe && !frame_o)
		else $error("lines not released");
	a_conv_quiet: assert property (frame_o && !conv_done_o |-> !la.dout && !lb.dout)
		else $error("data during conversion");
	a_lines_pair: assert property (la.oe == lb.oe)
		else $error("lines not paired");
	a_msb_track: assert property ($rose(conv_done_o) |-> track_o && frame_o)
		else $error("no tracking at edge 15");
	a_abort_sample: assert property ($fell(frame_o) |-> ##[0:1] track_o)
		else $error("no sampling after close");
	a_shift_edge: assert property (la.oe && $past(la.oe) && $changed(la.dout) |-> age inside {[1:6]})
		else $error("bit moved off clock fall");
	a_idle_quiet: assert property ((!frame_o) [*2] |-> !la.oe)
		else $error("driving outside frame");
endmodule // dasr_props
bind dasr_core dasr_props u_props (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .pins_i(pins_i),
	.result_line_first_o(result_line_first_o), .result_line_second_o(result_line_second_o),
	.track_o(track_o), .frame_o(frame_o), .conv_done_o(conv_done_o));
`default_nettype wire

// [dv/dasr_host.sv]
// host model: frames select and clock, captures both lines
`timescale 1ns/1ns
`default_nettype none
module dasr_host
	import dasr_pkg::*;
(
	output var  dasr_pins_s  pins_o,  // select and clock
	input  wire dasr_dout_s  la_i,    // line a
	input  wire dasr_dout_s  lb_i,    // line b
	output var  logic [31:0] cap_a_o, // bit after each fall, a
	output var  logic [31:0] cap_b_o, // same, b
	output var  logic        cap_v_o  // capture ready pulse
);
	initial begin
		pins_o = 2'b11;
		cap_v_o = 1'b0;
	end
	// released line floats: show the inverse of its last level
	function automatic logic seen(input dasr_pkg::dasr_dout_s l);
		return l.oe ? l.dout : ~l.dout;
	endfunction
	// n falls, clock stands high between frames
	task automatic frame(input int n);
		cap_a_o = '0;
		cap_b_o = '0;
		pins_o.frame_sel_b = 1'b0;
		#320;
		for (int k = 0; k <= n; k++) begin
			cap_a_o[31 - k] = seen(la_i);
			cap_b_o[31 - k] = seen(lb_i);
			if (k < n) begin
				pins_o.sclk = 1'b0;
				#160;
				pins_o.sclk = 1'b1;
				#160;
			end
		end
		pins_o.frame_sel_b = 1'b1;
		cap_v_o = 1'b1;
		#1;
		cap_v_o = 1'b0;
		#400;
	endtask
endmodule // dasr_host
`default_nettype wire

// [dv/dual_adc_serial_readout_test.sv]
// testbench: all resolutions, aborts, scoreboard
`timescale 1ns/1ns
`default_nettype none
module dual_adc_serial_readout_test;
	import dasr_pkg::*;
	logic        clk_sys_i = 1'b0;
	logic        rst_b_i = 1'b0;
	dasr_pins_s  pins;
	dasr_res_e   res = DASR_RES_16;
	logic [15:0] sa = '0, sb = '0;
	dasr_dout_s  la, lb;
	logic        track, frame, done, cv, ed;
	logic [31:0] ca, cb, ea, eb, em;
	logic [31:0] qa[$], qb[$], qm[$];
	logic        qd[$];
	logic [15:0] nf[3] = '{DASR_NEGATIVE_FULL_SCALE_CODE_16, DASR_NEGATIVE_FULL_SCALE_CODE_14, DASR_NEGATIVE_FULL_SCALE_CODE_12};
	logic [15:0] pf[3] = '{DASR_POSITIVE_FULL_SCALE_CODE_16, DASR_POSITIVE_FULL_SCALE_CODE_14, DASR_POSITIVE_FULL_SCALE_CODE_12};
	int          cut[6] = '{10, 14, 15, 20, 0, 31};
	int          err_total = 0, total_checks = 0, seed = 54020;
	always #20 clk_sys_i = ~clk_sys_i;
	dasr_core uut (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .pins_i(pins), .res_i(res),
		.sample_a_i(sa), .sample_b_i(sb), .result_line_first_o(la),
		.result_line_second_o(lb), .track_o(track), .frame_o(frame), .conv_done_o(done));
	dasr_host host (.pins_o(pins), .la_i(la), .lb_i(lb), .cap_a_o(ca), .cap_b_o(cb),
		.cap_v_o(cv));
	task automatic run(input int r, input logic [15:0] a, b, input int n);
		logic [15:0] m;
		logic [4:0]  nb;
		nb = r == 0 ? DASR_BITS_16 : r == 1 ? DASR_BITS_14 : DASR_BITS_12;
		m = r == 0 ? DASR_MASK_16 : r == 1 ? DASR_MASK_14 : DASR_MASK_12;
		@(posedge clk_sys_i);
		#2;
		res = dasr_res_e'(r);
		sa = a & m;
		sb = b & m;
		qa.push_back({15'h0, 16'(sa << (16 - nb)), 1'b0});
		qb.push_back({15'h0, 16'(sb << (16 - nb)), 1'b0});
		qm.push_back(~(32'hffff_ffff >> (n + 1)));
		qd.push_back(n >= 15);
		host.frame(n);
	endtask
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	always @(posedge cv) begin
		ea = qa.pop_front();
		eb = qb.pop_front();
		em = qm.pop_front();
		ed = qd.pop_front();
		total_checks += 3;
		if (((ca ^ ea) & em) !== '0 || ((cb ^ eb) & em) !== '0) begin
			err_total++;
			$display("mismatch %0t: data %h %h", $time, ca, cb);
		end
		if ({done, track} !== {ed, ed}) begin
			err_total++;
			$display("mismatch %0t: done/track", $time);
		end
		if ({frame, la.oe, lb.oe} !== 3'b111) begin
			err_total++;
			$display("mismatch %0t: frame/drive", $time);
		end
		$display("test %0d done", total_checks / 3);
	end
	initial begin
		repeat (12) @(posedge clk_sys_i);
		#2;
		rst_b_i = 1'b1;
		for (int i = 0; i < 3; i++) begin
			run(i, nf[i], pf[i], 31);
			run(i, 16'hffff, pf[i], 31);
			run(i, 16'($random(seed)), 16'($random(seed)), 31 - 2 * i);
		end
		foreach (cut[j]) run(0, 16'($random(seed)), 16'($random(seed)), cut[j]);
		report_and_stop();
	end
	initial begin
		#1_000_000;
		err_total++;
		$display("mismatch %0t: timeout", $time);
		report_and_stop();
	end
endmodule // dual_adc_serial_readout_test
`default_nettype wire
